// ==== rtl/cycle_timing_outputs.sv ====
// cycle timing, control pulses, serial clock dividers and status pins
// Functional notes
// - line_fault_n is driven low when the receive line is distorted or missing.
// - communication cycles restart on the programmed edge of cycle_sync_in.
// - control_pulse_out is active once per cycle at a programmed time, polarity and width.
// - divided pulses repeat several times a cycle or once in several cycles, all programmable.
// - each divided pulse ends exactly 1 us after its last trigger.
// - serial_clock_div_a is the serial clock divided by 2 or 1.
// - serial_clock_div_b is the serial clock divided by 4 or 2.
// - output_float_in high floats the pins, stops the clocks and resets the logic.
// - test_chain_out keeps driving while the other outputs float.
// - watchdog expiry shows on watchdog_out_n, active low.
// - the clock regeneration loop is used only when the compat strap is 0.
// - compat strap 1 selects the legacy mode, and with the baud strap the baud rate.
`timescale 1ns/1ns
`default_nettype none
`include "cycle_timing_map.svh"
module cycle_timing_outputs (
  // clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         reset_n_in,
  input  wire logic                         serial_clk_in,
  // pins
  input  wire logic                         cycle_sync_in,
  input  wire logic                         output_float_in,
  input  wire logic                         compat_mode_strap_in,
  input  wire logic                         baud_strap_in,
  // configuration and internal status
  input  wire cycle_timing_pkg::timing_cfg_t cfg_in,
  input  wire cycle_timing_pkg::sclk_cfg_t   sclk_cfg_in,
  input  wire logic                         line_bad_in,
  input  wire logic                         watchdog_expired_in,
  input  wire logic                         test_chain_in,
  // outputs with enables
  output logic                              line_fault_n_out,
  output logic                              watchdog_out_n_out,
  output logic                              control_pulse_out,
  output logic                              div_pulse_out,
  output logic                              serial_clock_div_a_out,
  output logic                              serial_clock_div_b_out,
  output logic                              pins_oe_out,
  output logic                              test_chain_out,
  output logic                              cycle_start_out,
  output logic                              compat_mode_out,
  output logic                              regen_loop_en_out,
  output logic [1:0]                        baud_sel_out
);
  logic                        sync_a_reg, sync_b_reg, sync_c_reg;
  logic                        flt_a_reg, flt_b_reg;
  logic                        sflt_a_reg, sflt_b_reg;
  logic                        strap_a_reg, strap_b_reg, baud_a_reg, baud_b_reg;
  logic                        run_rst;
  logic                        cyc_edge;
  logic [`TIME_W-1:0]          cyc_time_reg;
  logic [`TIME_W-1:0]          ctl_left_reg;
  logic [`TIME_W-1:0]          div_tmr_reg;
  logic [`TIME_W-1:0]          width_reg;
  logic [`COUNT_W-1:0]         div_left_reg;
  logic [`COUNT_W-1:0]         skip_reg;
  logic                        ctl_act_reg, div_act_reg;
  cycle_timing_pkg::div_state_t div_st_reg;
  logic [1:0]                  sdiv_reg;

  // output float pin synchronised; the block is held in reset while it is high
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flt_a_reg <= 1'b0;
      flt_b_reg <= 1'b0;
    end else begin
      flt_a_reg <= output_float_in;
      flt_b_reg <= flt_a_reg;
    end
  end
  assign run_rst = flt_b_reg;

  // straps sampled on every clock, through two flops
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_a_reg <= 1'b0;
      strap_b_reg <= 1'b0;
      baud_a_reg  <= 1'b0;
      baud_b_reg  <= 1'b0;
    end else begin
      strap_a_reg <= compat_mode_strap_in;
      strap_b_reg <= strap_a_reg;
      baud_a_reg  <= baud_strap_in;
      baud_b_reg  <= baud_a_reg;
    end
  end
  assign compat_mode_out   = strap_b_reg;
  assign baud_sel_out      = {strap_b_reg, baud_b_reg};
  assign regen_loop_en_out = ~strap_b_reg & ~run_rst;

  // cycle clock synchroniser; only the second and third stages feed the edge detector
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
      sync_c_reg <= 1'b0;
    end else begin
      sync_a_reg <= cycle_sync_in;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
    end
  end
  assign cyc_edge = cfg_in.sync_pol ? (sync_b_reg & ~sync_c_reg)
                                    : (~sync_b_reg & sync_c_reg);

  // cycle time base, restarted by each active edge
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cyc_time_reg    <= `TIME_ZERO;
      cycle_start_out <= 1'b0;
    end else if (run_rst) begin
      cyc_time_reg    <= `TIME_ZERO;
      cycle_start_out <= 1'b0;
    end else begin
      cycle_start_out <= cyc_edge;
      if (cyc_edge) begin
        cyc_time_reg <= `TIME_ZERO;
      end else if (cyc_time_reg != `TIME_MAX) begin
        cyc_time_reg <= cyc_time_reg + `TIME_ONE;
      end
    end
  end

  // control pulse: starts at the programmed time, once per cycle
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_act_reg  <= 1'b0;
      ctl_left_reg <= `TIME_ZERO;
    end else if (run_rst || cyc_edge) begin
      ctl_act_reg  <= 1'b0;
      ctl_left_reg <= `TIME_ZERO;
    end else if (!ctl_act_reg && cyc_time_reg == cfg_in.ctl_start
                 && cfg_in.ctl_width != `TIME_ZERO) begin
      ctl_act_reg  <= 1'b1;
      ctl_left_reg <= cfg_in.ctl_width - `TIME_ONE;
    end else if (ctl_act_reg) begin
      if (ctl_left_reg == `TIME_ZERO) begin
        ctl_act_reg <= 1'b0;
      end else begin
        ctl_left_reg <= ctl_left_reg - `TIME_ONE;
      end
    end
  end

  // divided pulse train scheduler
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_st_reg   <= cycle_timing_pkg::DIV_IDLE;
      div_tmr_reg  <= `TIME_ZERO;
      div_left_reg <= `COUNT_ZERO;
      skip_reg     <= `COUNT_ZERO;
    end else if (run_rst) begin
      div_st_reg   <= cycle_timing_pkg::DIV_IDLE;
      div_tmr_reg  <= `TIME_ZERO;
      div_left_reg <= `COUNT_ZERO;
      skip_reg     <= `COUNT_ZERO;
    end else if (cyc_edge) begin
      // in skip mode only every div_skip-th cycle starts a train
      if (cfg_in.div_multi || skip_reg == `COUNT_ZERO) begin
        div_st_reg   <= cycle_timing_pkg::DIV_WAIT;
        div_left_reg <= cfg_in.div_multi ? cfg_in.div_count : `COUNT_ONE;
        skip_reg     <= cfg_in.div_multi ? `COUNT_ZERO
                        : ((cfg_in.div_skip == `COUNT_ZERO) ? `COUNT_ZERO
                        : cfg_in.div_skip - `COUNT_ONE);
      end else begin
        div_st_reg <= cycle_timing_pkg::DIV_IDLE;
        skip_reg   <= skip_reg - `COUNT_ONE;
      end
      div_tmr_reg <= `TIME_ZERO;
    end else begin
      case (div_st_reg)
        cycle_timing_pkg::DIV_IDLE: begin
          div_tmr_reg <= `TIME_ZERO;
        end
        cycle_timing_pkg::DIV_WAIT: begin
          if (div_left_reg == `COUNT_ZERO) begin
            div_st_reg <= cycle_timing_pkg::DIV_IDLE;
          end else if (cyc_time_reg == cfg_in.div_start) begin
            div_st_reg  <= cycle_timing_pkg::DIV_RUN;
            div_tmr_reg <= `TIME_ZERO;
          end
        end
        cycle_timing_pkg::DIV_RUN: begin
          if (div_left_reg == `COUNT_ZERO) begin
            div_st_reg <= cycle_timing_pkg::DIV_IDLE;
          end else if (div_tmr_reg == `TIME_ZERO) begin
            div_left_reg <= div_left_reg - `COUNT_ONE;
            div_tmr_reg  <= (cfg_in.div_period == `TIME_ZERO) ? `TIME_ZERO
                            : cfg_in.div_period - `TIME_ONE;
          end else begin
            div_tmr_reg <= div_tmr_reg - `TIME_ONE;
          end
        end
        default: begin
          div_st_reg <= cycle_timing_pkg::DIV_IDLE;
        end
      endcase
    end
  end

  // fixed 1 us width, counted in master clock cycles; a retrigger inside a pulse restarts it
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_act_reg <= 1'b0;
      width_reg   <= `TIME_ZERO;
    end else if (run_rst) begin
      div_act_reg <= 1'b0;
      width_reg   <= `TIME_ZERO;
    end else if (div_st_reg == cycle_timing_pkg::DIV_RUN && !cyc_edge
                 && div_left_reg != `COUNT_ZERO && div_tmr_reg == `TIME_ZERO) begin
      div_act_reg <= 1'b1;
      width_reg   <= `DIV_PULSE_CYC_W - `TIME_ONE;
    end else if (div_act_reg) begin
      if (width_reg == `TIME_ZERO) begin
        div_act_reg <= 1'b0;
      end else begin
        width_reg <= width_reg - `TIME_ONE;
      end
    end
  end

  // registered pin levels
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      control_pulse_out  <= 1'b0;
      div_pulse_out      <= 1'b0;
      line_fault_n_out   <= 1'b1;
      watchdog_out_n_out <= 1'b1;
      pins_oe_out        <= 1'b0;
      test_chain_out     <= 1'b0;
    end else begin
      control_pulse_out  <= ctl_act_reg ^ ~cfg_in.ctl_pol;
      div_pulse_out      <= div_act_reg ^ ~cfg_in.div_pol;
      line_fault_n_out   <= ~(line_bad_in & ~run_rst);
      watchdog_out_n_out <= ~(watchdog_expired_in & ~run_rst);
      pins_oe_out        <= ~run_rst;
      test_chain_out     <= test_chain_in;
    end
  end

  // float level crosses into the serial clock domain through two flops of its own
  always_ff @(posedge serial_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sflt_a_reg <= 1'b0;
      sflt_b_reg <= 1'b0;
    end else begin
      sflt_a_reg <= flt_b_reg;
      sflt_b_reg <= sflt_a_reg;
    end
  end

  // serial clock divider; stopped and cleared while floated
  // limitation: the 1:1 output is a gated clock and may show one short high phase at float
  always_ff @(posedge serial_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sdiv_reg <= 2'h0;
    end else if (sflt_b_reg) begin
      sdiv_reg <= 2'h0;
    end else begin
      sdiv_reg <= sdiv_reg + 2'h1;
    end
  end
  // half settings pick the faster ratio; 1:1 passes the clock itself
  assign serial_clock_div_a_out = sclk_cfg_in.div_a_half ? (serial_clk_in & ~sflt_b_reg)
                                                         : sdiv_reg[0];
  assign serial_clock_div_b_out = sclk_cfg_in.div_b_half ? sdiv_reg[0]
                                                         : sdiv_reg[1];
endmodule
`default_nettype wire

// ==== rtl/cycle_timing_map.svh ====
// constants for the cycle timing outputs block
`ifndef CYCLE_TIMING_MAP_SVH
`define CYCLE_TIMING_MAP_SVH
`define CLK_MHZ           25
`define DIV_PULSE_NS      1000
`define DIV_PULSE_CYC     ((`DIV_PULSE_NS * `CLK_MHZ) / 1000)
`define DIV_PULSE_CYC_W   16'(`DIV_PULSE_CYC)
`define RESET_MIN_NS      50
`define TIME_W            16
`define COUNT_W           8
`define TIME_ZERO         16'h0000
`define COUNT_ZERO        8'h00
`define COUNT_ONE         8'h01
`define TIME_ONE          16'h0001
`define TIME_MAX          16'hffff
`endif

// ==== rtl/cycle_timing_pkg.sv ====
// types for the cycle timing outputs block
`default_nettype none
package cycle_timing_pkg;
  typedef struct packed {
    logic        sync_pol;
    logic [15:0] ctl_start;
    logic [15:0] ctl_width;
    logic        ctl_pol;
    logic        div_multi;
    logic [7:0]  div_count;
    logic [15:0] div_start;
    logic [15:0] div_period;
    logic [7:0]  div_skip;
    logic        div_pol;
  } timing_cfg_t;
  typedef struct packed {
    logic div_a_half;
    logic div_b_half;
  } sclk_cfg_t;
  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_WAIT = 3'b010,
    DIV_RUN  = 3'b100
  } div_state_t;
endpackage
`default_nettype wire

// ==== sim/cycle_timing_outputs_checker.sv ====
// assertion checker for the cycle timing outputs block
`timescale 1ns/1ns
`default_nettype none
module cycle_timing_outputs_checker (
  // clock and reset
  input wire logic                          ref_clk_in,
  input wire logic                          reset_n_in,
  // inputs
  input wire logic                          cycle_sync_in,
  input wire logic                          output_float_in,
  input wire logic                          compat_mode_strap_in,
  input wire cycle_timing_pkg::timing_cfg_t cfg_in,
  input wire logic                          line_bad_in,
  input wire logic                          watchdog_expired_in,
  input wire logic                          test_chain_in,
  // outputs
  input wire logic                          line_fault_n_out,
  input wire logic                          watchdog_out_n_out,
  input wire logic                          div_pulse_out,
  input wire logic                          pins_oe_out,
  input wire logic                          test_chain_out,
  input wire logic                          cycle_start_out,
  input wire logic                          compat_mode_out,
  input wire logic                          regen_loop_en_out
);
  logic       act;
  logic [7:0] run_reg;
  assign act = div_pulse_out == cfg_in.div_pol;
  // length of the current divided pulse in master clock cycles
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) run_reg <= 8'h00;
    else run_reg <= act ? run_reg + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_line_fault_low: assert property (pins_oe_out && $past(pins_oe_out) |=>
    !pins_oe_out || line_fault_n_out != $past(line_bad_in)) else $error("line fault level wrong");
  a_watchdog_low: assert property (pins_oe_out && $past(pins_oe_out) |=>
    !pins_oe_out || watchdog_out_n_out != $past(watchdog_expired_in)) else $error("watchdog wrong");
  a_sync_edge: assert property (cycle_start_out |->
    ($past(cycle_sync_in, 3) == cfg_in.sync_pol && $past(cycle_sync_in, 4) != cfg_in.sync_pol) ||
    ($past(cycle_sync_in, 4) == cfg_in.sync_pol && $past(cycle_sync_in, 5) != cfg_in.sync_pol))
    else $error("cycle start without sync edge");
  a_start_single: assert property (cycle_start_out |=> !cycle_start_out)
    else $error("cycle start longer than one cycle");
  // a polarity change flips the idle level for one cycle, so it is excluded
  a_div_width: assert property ($fell(act) && pins_oe_out && $past(pins_oe_out) &&
    $past(cfg_in.div_pol, 2) == cfg_in.div_pol |-> run_reg == 8'h19) else $error("div width wrong");
  a_float_off: assert property (output_float_in[*4] |-> !pins_oe_out && !cycle_start_out)
    else $error("pins driven while floated");
  a_float_back: assert property (!output_float_in[*6] |-> pins_oe_out)
    else $error("pins not driven after float");
  a_test_drive: assert property ($past(reset_n_in) |-> test_chain_out == $past(test_chain_in))
    else $error("test chain not driven");
  a_regen_compat: assert property (!output_float_in[*3] |-> regen_loop_en_out == !compat_mode_out)
    else $error("regen loop on in compat mode");
  a_compat_follow: assert property (compat_mode_strap_in[*4] ##0 pins_oe_out |-> compat_mode_out)
    else $error("compat mode not taken");
  c_cycle_start: cover property ($rose(cycle_start_out));
  c_div_pulse: cover property ($fell(act) && pins_oe_out);
  c_float: cover property (output_float_in[*4]);
endmodule
bind cycle_timing_outputs cycle_timing_outputs_checker i_checker (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cycle_sync_in(cycle_sync_in),
  .output_float_in(output_float_in), .compat_mode_strap_in(compat_mode_strap_in),
  .cfg_in(cfg_in), .line_bad_in(line_bad_in), .watchdog_expired_in(watchdog_expired_in),
  .test_chain_in(test_chain_in), .line_fault_n_out(line_fault_n_out),
  .watchdog_out_n_out(watchdog_out_n_out), .div_pulse_out(div_pulse_out),
  .pins_oe_out(pins_oe_out), .test_chain_out(test_chain_out),
  .cycle_start_out(cycle_start_out), .compat_mode_out(compat_mode_out),
  .regen_loop_en_out(regen_loop_en_out));
`default_nettype wire

// ==== sim/cycle_sync_source.sv ====
// cycle clock source standing in for the motion controller
`timescale 1ns/1ns
`default_nettype none
module cycle_sync_source #(
  parameter int PERIOD = 400
) (
  input  wire logic ref_clk_in,
  input  wire logic run_in,
  input  wire logic pol_in,
  output logic      sync_out
);
  int cnt = 0;
  // active level held 8 cycles so two sampling flops always catch it
  always @(posedge ref_clk_in) begin
    cnt <= run_in ? (cnt + 1) % PERIOD : 0;
    sync_out <= #2 (run_in && cnt < 8) ? pol_in : !pol_in;
  end
endmodule
`default_nettype wire

// ==== sim/test_cycle_timing_outputs.sv ====
// self-checking bench for the cycle timing outputs block
`timescale 1ns/1ns
`default_nettype none
module test_cycle_timing_outputs;
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, serial_clk_in = 1'b0, run = 1'b0, div_prev = 1'b0;
  logic ctl_prev = 1'b0;
  int   t_cs = 0, ctl_ofs = 0;
  logic output_float_in, compat_mode_strap_in, baud_strap_in, cycle_sync_in;
  logic line_bad_in, watchdog_expired_in, test_chain_in, line_fault_n_out, watchdog_out_n_out;
  logic control_pulse_out, div_pulse_out, serial_clock_div_a_out, serial_clock_div_b_out;
  logic pins_oe_out, test_chain_out, cycle_start_out, compat_mode_out, regen_loop_en_out;
  logic [1:0] baud_sel_out;
  cycle_timing_pkg::timing_cfg_t cfg_in;
  cycle_timing_pkg::sclk_cfg_t   sclk_cfg_in;
  int errors = 0, n_tests = 0, n_ctl, n_div, n_cs, na, nb, q[$];
  cycle_timing_outputs i_dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .serial_clk_in(serial_clk_in),
    .cycle_sync_in(cycle_sync_in), .output_float_in(output_float_in),
    .compat_mode_strap_in(compat_mode_strap_in), .baud_strap_in(baud_strap_in),
    .cfg_in(cfg_in), .sclk_cfg_in(sclk_cfg_in), .line_bad_in(line_bad_in),
    .watchdog_expired_in(watchdog_expired_in), .test_chain_in(test_chain_in),
    .line_fault_n_out(line_fault_n_out), .watchdog_out_n_out(watchdog_out_n_out),
    .control_pulse_out(control_pulse_out), .div_pulse_out(div_pulse_out),
    .serial_clock_div_a_out(serial_clock_div_a_out),
    .serial_clock_div_b_out(serial_clock_div_b_out), .pins_oe_out(pins_oe_out),
    .test_chain_out(test_chain_out), .cycle_start_out(cycle_start_out),
    .compat_mode_out(compat_mode_out), .regen_loop_en_out(regen_loop_en_out),
    .baud_sel_out(baud_sel_out));
  cycle_sync_source i_src (.ref_clk_in(ref_clk_in), .run_in(run), .pol_in(cfg_in.sync_pol),
    .sync_out(cycle_sync_in));
  always #20 ref_clk_in = ~ref_clk_in;
  always #8 serial_clk_in = ~serial_clk_in;
  always @(posedge serial_clock_div_a_out) na++;
  always @(posedge serial_clock_div_b_out) nb++;
  always @(posedge ref_clk_in) begin
    n_ctl += (control_pulse_out === cfg_in.ctl_pol);
    n_div += (div_pulse_out === cfg_in.div_pol && !div_prev);
    div_prev = div_pulse_out === cfg_in.div_pol;
    n_cs += (cycle_start_out === 1'b1);
    // cycles from the cycle start to the first active control level
    t_cs = (cycle_start_out === 1'b1) ? 0 : t_cs + 1;
    if (control_pulse_out === cfg_in.ctl_pol && !ctl_prev) ctl_ofs = t_cs;
    ctl_prev = control_pulse_out === cfg_in.ctl_pol;
  end
  task step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(47388));
    {output_float_in, compat_mode_strap_in, baud_strap_in} = 3'h0;
    {line_bad_in, watchdog_expired_in, test_chain_in} = 3'h0;
    cfg_in = '0;
    sclk_cfg_in = '0;
    step(2);
    reset_n_in = 1'b1;
    for (int k = 0; k < 4; k++) begin
      sclk_cfg_in = 2'(k);
      step(4);
      @(negedge serial_clk_in) {na, nb} = 64'h0;
      repeat (64) @(negedge serial_clk_in);
      chk("div_a", k[1] ? 64 : 32, na);
      chk("div_b", k[0] ? 32 : 16, nb);
      step(1);
    end
    repeat (8) begin
      {line_bad_in, watchdog_expired_in, test_chain_in, compat_mode_strap_in, baud_strap_in} =
        5'($urandom);
      step(5);
      chk("line_fault", !line_bad_in, line_fault_n_out);
      chk("watchdog", !watchdog_expired_in, watchdog_out_n_out);
      chk("baud_sel", {compat_mode_strap_in, baud_strap_in}, baud_sel_out);
      chk("regen", !compat_mode_strap_in, regen_loop_en_out);
      chk("compat", compat_mode_strap_in, compat_mode_out);
      chk("test_chain_run", test_chain_in, test_chain_out);
    end
    for (int r = 0; r < 4; r++) begin
      cfg_in = '{sync_pol: 1'($urandom), ctl_start: 16'(5 + $urandom % 30),
        ctl_width: 16'(1 + $urandom % 20), ctl_pol: 1'($urandom), div_multi: r[0],
        div_count: 8'(1 + $urandom % 3), div_start: 16'h0028, div_period: 16'h0028,
        div_skip: 8'(2 << ($urandom % 2)), div_pol: 1'($urandom)};
      step(10);
      {n_ctl, n_div, n_cs} = 96'h0;
      run = 1'b1;
      step(1600);
      run = 1'b0;
      step(450);
      // four cycles: a skip of 2 or 4 gives an exact count whatever the phase
      q = {4, 4 * int'(cfg_in.ctl_width),
        cfg_in.div_multi ? 4 * int'(cfg_in.div_count) : 4 / int'(cfg_in.div_skip)};
      chk("cycle_starts", q.pop_front(), n_cs);
      chk("ctl_active", q.pop_front(), n_ctl);
      chk("ctl_time", int'(cfg_in.ctl_start) + 2, ctl_ofs);
      chk("div_pulses", q.pop_front(), n_div);
    end
    output_float_in = 1'b1;
    test_chain_in = 1'b1;
    step(6);
    @(negedge serial_clk_in) na = 0;
    step(10);
    chk("float_clk", 0, na);
    chk("float_oe", 0, pins_oe_out);
    chk("test_chain", 1, test_chain_out);
    output_float_in = 1'b0;
    for (int i = 0; i < 10 && pins_oe_out !== 1'b1; i++) step(1);
    chk("oe_back", 1, pins_oe_out);
    report_and_stop;
  end
  initial begin
    #2000000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
